// ### src/ocm_subsystem.sv
// On-chip memory subsystem: configurable direct-mapped cache and relocatable SRAM
`timescale 1ns/1ps
module ocm_subsystem
  import ocm_pkg::*;
(
  input wire logic i_clk, // System clock, 200 MHz
  input wire logic i_rstn, // Asynchronous reset, active low
  input wire logic i_cfg_wr, // Cache config write strobe
  input wire logic i_cfg_super, // Writer is in supervisor mode
  input wire logic [CFG_W-1:0] i_cfg_wdata, // Cache config write data
  output logic [CFG_W-1:0] o_cfg_rdata, // Cache config readback
  output logic o_cfg_busy, // Invalidation sweep running
  input wire logic i_base_wr, // SRAM base write strobe
  input wire logic [ADDR_W-1:0] i_base_wdata, // SRAM base and enable
  output logic [ADDR_W-1:0] o_base_rdata, // SRAM base readback
  input wire logic i_core_req, // Core or debug request, held to ack
  input wire logic i_core_we, // Core write
  input wire logic [BE_W-1:0] i_core_be, // Core byte enables
  input wire logic i_core_ifetch, // Instruction fetch
  input wire logic [ADDR_W-1:0] i_core_addr, // Core address
  input wire logic [DATA_W-1:0] i_core_wdata, // Core write data
  output logic o_core_ack, // Core access done
  output logic [DATA_W-1:0] o_core_rdata, // Core read data
  input wire logic i_dma_req, // DMA request, held to ack
  input wire logic i_dma_we, // DMA write
  input wire logic [BE_W-1:0] i_dma_be, // DMA byte enables
  input wire logic [ADDR_W-1:0] i_dma_addr, // DMA address
  input wire logic [DATA_W-1:0] i_dma_wdata, // DMA write data
  output logic o_dma_ack, // DMA access done
  output logic o_dma_err, // DMA address outside window
  output logic [DATA_W-1:0] o_dma_rdata, // DMA read data
  output logic o_sys_req, // System bus request
  output logic o_sys_we, // System bus write
  output logic [BE_W-1:0] o_sys_be, // System bus byte enables
  output logic [ADDR_W-1:0] o_sys_addr, // System bus address
  output logic [DATA_W-1:0] o_sys_wdata, // System bus write data
  input wire logic i_sys_ack, // System bus done
  input wire logic [DATA_W-1:0] i_sys_rdata // System bus read data
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_SRAM, ST_LOOK, ST_SYS, ST_RESP} core_state_t;

  // Address falls in the enabled SRAM window
  function automatic logic in_window(input logic [ADDR_W-1:0] a, input logic [16:0] b);
    in_window = b[BASE_EN_BIT] && (a[ADDR_W-1:BASE_LSB] == b[16:1]);
  endfunction

  // Cache index: split mode gives each stream one half
  function automatic logic [WORD_AW-1:0] cache_idx(input logic [ADDR_W-1:0] a,
                                                  input logic ifetch, input logic [1:0] m);
    if (m == MODE_SPLIT) begin
      cache_idx = {~ifetch, a[TAG_LSB-1:IDX_LSB]};
    end else begin
      cache_idx = a[BLK_LSB-1:IDX_LSB];
    end
  endfunction

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [RST_STAGES-1:0] rst_sync_reg;
  logic rstn;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync_reg <= '0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[RST_STAGES-2:0], 1'b1};
    end
  end
  assign rstn = rst_sync_reg[RST_STAGES-1];

  // ----------------------------------------
  // Core path state
  // ----------------------------------------
  core_state_t state_reg, state_next;
  logic [CFG_W-1:0] cfg_reg, cfg_next;
  logic [16:0] base_reg, base_next;
  logic inv_pend_reg, inv_pend_next;
  logic [WORD_AW-1:0] inv_cnt_reg, inv_cnt_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic we_reg, we_next;
  logic [BE_W-1:0] be_reg, be_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic cacheable_reg, cacheable_next;
  logic [WORD_AW-1:0] idx_reg, idx_next;
  logic [1:0] blk_reg, blk_next;
  logic sys_req_reg, sys_req_next;
  logic [DATA_W-1:0] fill_reg, fill_next;
  logic [1:0] mode;
  logic core_take, core_win, use_cache, hit;
  logic [WORD_AW-1:0] idx_in;
  logic [TAGE_W-1:0] tag_rd;
  logic [DATA_W-1:0] cdata_rd;
  logic tag_en, tag_we, data_en, data_we;
  logic [WORD_AW-1:0] tag_addr, data_addr;
  logic [TAGE_W-1:0] tag_wdata;
  logic [DATA_W-1:0] data_wdata;
  logic [DATA_W-1:0] sram_rdata [SRAM_BLOCKS];

  assign mode = cfg_reg[CFG_MODE_LSB +: 2];
  assign core_take = (state_reg == ST_IDLE) && !inv_pend_reg && i_core_req;
  assign core_win = in_window(i_core_addr, base_reg);
  assign use_cache = cfg_reg[CFG_EN_BIT] && ((mode == MODE_SPLIT) ||
                     (mode == MODE_ICACHE && i_core_ifetch) ||
                     (mode == MODE_DCACHE && !i_core_ifetch));
  assign idx_in = cache_idx(i_core_addr, i_core_ifetch, mode);
  assign hit = (tag_rd == {1'b1, addr_reg[ADDR_W-1:TAG_LSB]});

  // Next state of the core path and configuration
  always_comb begin
    state_next = state_reg;
    cfg_next = cfg_reg;
    base_next = base_reg;
    inv_pend_next = inv_pend_reg;
    inv_cnt_next = inv_cnt_reg;
    addr_next = addr_reg;
    we_next = we_reg;
    be_next = be_reg;
    wdata_next = wdata_reg;
    cacheable_next = cacheable_reg;
    idx_next = idx_reg;
    blk_next = blk_reg;
    sys_req_next = sys_req_reg;
    fill_next = fill_reg;
    if (i_base_wr) begin
      base_next = {i_base_wdata[ADDR_W-1:BASE_LSB], i_base_wdata[BASE_EN_BIT]};
    end
    case (state_reg)
      ST_INIT: begin
        inv_cnt_next = inv_cnt_reg + 1'b1;
        if (inv_cnt_reg == WORD_AW'(WORDS - 1)) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (inv_pend_reg) begin
          inv_pend_next = 1'b0;
          inv_cnt_next = '0;
          state_next = ST_INIT;
        end else if (core_take) begin
          addr_next = i_core_addr;
          we_next = i_core_we;
          be_next = i_core_be;
          wdata_next = i_core_wdata;
          idx_next = idx_in;
          blk_next = i_core_addr[BLK_LSB +: 2];
          cacheable_next = use_cache;
          if (core_win) begin
            state_next = ST_SRAM;
          end else if (use_cache && !i_core_we) begin
            state_next = ST_LOOK;
          end else begin
            state_next = ST_SYS;
            sys_req_next = 1'b1;
          end
        end
      end
      ST_SRAM: state_next = ST_IDLE;
      ST_LOOK: begin
        if (hit) begin
          state_next = ST_IDLE;
        end else begin
          state_next = ST_SYS;
          sys_req_next = 1'b1;
        end
      end
      ST_SYS: begin
        if (i_sys_ack) begin
          sys_req_next = 1'b0;
          fill_next = i_sys_rdata;
          state_next = ST_RESP;
        end
      end
      ST_RESP: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
    // Privileged write; a new request wins over the sweep clearing it
    if (i_cfg_wr && i_cfg_super) begin
      cfg_next = i_cfg_wdata & ~(CFG_W'(1) << CFG_INV_BIT);
      inv_pend_next = 1'b1;
    end
  end

  // Core path registers
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      cfg_reg <= CFG_RESET;
      base_reg <= BASE_RESET;
      inv_pend_reg <= 1'b1;
      inv_cnt_reg <= '0;
      addr_reg <= '0;
      we_reg <= 1'b0;
      be_reg <= '0;
      wdata_reg <= '0;
      cacheable_reg <= 1'b0;
      idx_reg <= '0;
      blk_reg <= '0;
      sys_req_reg <= 1'b0;
      fill_reg <= '0;
    end else begin
      state_reg <= state_next;
      cfg_reg <= cfg_next;
      base_reg <= base_next;
      inv_pend_reg <= inv_pend_next;
      inv_cnt_reg <= inv_cnt_next;
      addr_reg <= addr_next;
      we_reg <= we_next;
      be_reg <= be_next;
      wdata_reg <= wdata_next;
      cacheable_reg <= cacheable_next;
      idx_reg <= idx_next;
      blk_reg <= blk_next;
      sys_req_reg <= sys_req_next;
      fill_reg <= fill_next;
    end
  end

  // ----------------------------------------
  // Cache array control
  // ----------------------------------------
  // Sweep, lookup, write invalidate and line fill
  always_comb begin
    tag_en = 1'b0;
    tag_we = 1'b0;
    tag_addr = idx_in;
    tag_wdata = '0;
    data_en = 1'b0;
    data_we = 1'b0;
    data_addr = idx_in;
    data_wdata = i_sys_rdata;
    if (state_reg == ST_INIT) begin
      tag_en = 1'b1;
      tag_we = 1'b1;
      tag_addr = inv_cnt_reg;
    end else if (core_take && !inv_pend_reg && !core_win && use_cache) begin
      tag_en = 1'b1;
      tag_we = i_core_we; // write-through, drop the stale line
      data_en = !i_core_we;
    end else if (state_reg == ST_SYS && i_sys_ack && cacheable_reg && !we_reg) begin
      tag_en = 1'b1;
      tag_we = 1'b1;
      tag_addr = idx_reg;
      tag_wdata = {1'b1, addr_reg[ADDR_W-1:TAG_LSB]};
      data_en = 1'b1;
      data_we = 1'b1;
      data_addr = idx_reg;
    end
  end

  // Tag store and data store
  ocm_spram #(.WIDTH(TAGE_W), .LANES(1), .DEPTH(WORDS), .AW(WORD_AW)) u_tag (
    .i_clk(i_clk),
    .i_rstn(rstn),
    .i_en(tag_en),
    .i_we(tag_we),
    .i_be(1'b1),
    .i_addr(tag_addr),
    .i_wdata(tag_wdata),
    .o_rdata(tag_rd)
  );
  ocm_spram #(.WIDTH(DATA_W), .LANES(BE_W), .DEPTH(WORDS), .AW(WORD_AW)) u_cdata (
    .i_clk(i_clk),
    .i_rstn(rstn),
    .i_en(data_en),
    .i_we(data_we),
    .i_be({BE_W{1'b1}}),
    .i_addr(data_addr),
    .i_wdata(data_wdata),
    .o_rdata(cdata_rd)
  );

  // ----------------------------------------
  // SRAM blocks and DMA port
  // ----------------------------------------
  logic dma_ack_reg, dma_ack_next;
  logic dma_err_reg, dma_err_next;
  logic [1:0] dma_blk_reg, dma_blk_next;
  logic dma_win, core_claim, dma_go;

  assign dma_win = in_window(i_dma_addr, base_reg);
  assign core_claim = core_take && !inv_pend_reg && core_win;
  assign dma_go = i_dma_req && !dma_ack_reg && (!dma_win || !core_claim ||
                  (i_core_addr[BLK_LSB +: 2] != i_dma_addr[BLK_LSB +: 2]));

  // Per-block port steering, core first on a clash
  generate
    for (genvar b = 0; b < SRAM_BLOCKS; b++) begin : g_blk
      logic csel, dsel, en, we;
      logic [BE_W-1:0] be;
      logic [WORD_AW-1:0] addr;
      logic [DATA_W-1:0] wd;
      assign csel = core_claim && (i_core_addr[BLK_LSB +: 2] == 2'(b));
      assign dsel = dma_go && dma_win && !csel && (i_dma_addr[BLK_LSB +: 2] == 2'(b));
      assign en = csel || dsel;
      assign we = csel ? i_core_we : i_dma_we;
      assign be = csel ? i_core_be : i_dma_be;
      assign addr = csel ? i_core_addr[BLK_LSB-1:IDX_LSB] : i_dma_addr[BLK_LSB-1:IDX_LSB];
      assign wd = csel ? i_core_wdata : i_dma_wdata;
      ocm_spram #(.WIDTH(DATA_W), .LANES(BE_W), .DEPTH(WORDS), .AW(WORD_AW)) u_sram (
        .i_clk(i_clk),
        .i_rstn(rstn),
        .i_en(en),
        .i_we(we),
        .i_be(be),
        .i_addr(addr),
        .i_wdata(wd),
        .o_rdata(sram_rdata[b])
      );
    end
  endgenerate

  // DMA answer next values
  always_comb begin
    dma_ack_next = dma_go;
    dma_err_next = dma_go && !dma_win;
    dma_blk_next = dma_go ? i_dma_addr[BLK_LSB +: 2] : dma_blk_reg;
  end

  // DMA answer registers
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      dma_ack_reg <= 1'b0;
      dma_err_reg <= 1'b0;
      dma_blk_reg <= '0;
    end else begin
      dma_ack_reg <= dma_ack_next;
      dma_err_reg <= dma_err_next;
      dma_blk_reg <= dma_blk_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_core_ack = (state_reg == ST_SRAM) || (state_reg == ST_RESP) ||
                      (state_reg == ST_LOOK && hit);
  assign o_core_rdata = (state_reg == ST_SRAM) ? sram_rdata[blk_reg] :
                        (state_reg == ST_LOOK) ? cdata_rd : fill_reg;
  assign o_dma_ack = dma_ack_reg;
  assign o_dma_err = dma_err_reg;
  assign o_dma_rdata = sram_rdata[dma_blk_reg];
  assign o_sys_req = sys_req_reg;
  assign o_sys_we = we_reg;
  assign o_sys_be = be_reg;
  assign o_sys_addr = addr_reg;
  assign o_sys_wdata = wdata_reg;
  assign o_cfg_rdata = cfg_reg;
  assign o_cfg_busy = inv_pend_reg || (state_reg == ST_INIT);
  assign o_base_rdata = {base_reg[16:1], 15'h0000, base_reg[BASE_EN_BIT]};
endmodule // ocm_subsystem

// ### src/ocm_pkg.sv
// Shared constants for the on-chip cache and SRAM subsystem
package ocm_pkg;
  // ----------------------------------------
  // Bus widths
  // ----------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  // ----------------------------------------
  // Array geometry
  // ----------------------------------------
  localparam int SRAM_BLOCKS = 4;
  localparam int BLOCK_BYTES = 16384;
  localparam int CACHE_BYTES = 16384;
  localparam int WORD_AW = 12;
  localparam int WORDS = BLOCK_BYTES / BE_W;
  localparam int IDX_LSB = 2;
  localparam int BLK_LSB = 14;
  localparam int BASE_LSB = 16;
  localparam int TAG_LSB = 13;
  localparam int TAG_W = 19;
  localparam int TAGE_W = TAG_W + 1;
  // ----------------------------------------
  // Cache configuration field layout
  // ----------------------------------------
  localparam int CFG_W = 4;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_MODE_LSB = 1;
  localparam int CFG_INV_BIT = 3;
  localparam logic [1:0] MODE_ICACHE = 2'h0;
  localparam logic [1:0] MODE_DCACHE = 2'h1;
  localparam logic [1:0] MODE_SPLIT = 2'h2;
  localparam logic [CFG_W-1:0] CFG_RESET = 4'h0;
  // ----------------------------------------
  // SRAM base field layout
  // ----------------------------------------
  localparam int BASE_EN_BIT = 0;
  localparam logic [16:0] BASE_RESET = 17'h00000;
  // ----------------------------------------
  // Reset synchroniser depth
  // ----------------------------------------
  localparam int RST_STAGES = 2;
endpackage

// ### src/ocm_spram.sv
// Single-port synchronous SRAM with lane write enables and registered read data
`timescale 1ns/1ps
module ocm_spram #(
  parameter int WIDTH = 32,
  parameter int LANES = 4,
  parameter int DEPTH = 4096,
  parameter int AW = 12
) (
  input wire logic i_clk, // System clock
  input wire logic i_rstn, // Synchronised reset, active low
  input wire logic i_en, // Access enable
  input wire logic i_we, // Write when high
  input wire logic [LANES-1:0] i_be, // Lane enables
  input wire logic [AW-1:0] i_addr, // Word address
  input wire logic [WIDTH-1:0] i_wdata, // Write data
  output logic [WIDTH-1:0] o_rdata // Read data, one cycle after i_en
);
  localparam int LW = WIDTH / LANES;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdata_reg;

  // Array write, all enabled lanes in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_en && i_we) begin
      for (int l = 0; l < LANES; l++) begin
        if (i_be[l]) begin
          mem[i_addr][l*LW +: LW] <= i_wdata[l*LW +: LW];
        end
      end
    end
  end

  // Read port, old data on a same-cycle write
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_reg <= '0;
    end else if (i_en) begin
      rdata_reg <= mem[i_addr];
    end
  end

  assign o_rdata = rdata_reg;
endmodule // ocm_spram

// ### sim/ocm_subsystem_properties.sv
// Port-level assertion checker for the on-chip memory subsystem
`timescale 1ns/1ps
module ocm_subsystem_properties
  import ocm_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_rstn, // Raw reset, active low
  input wire logic i_cfg_wr, // Config write strobe
  input wire logic i_cfg_super, // Supervisor writer
  input wire logic [CFG_W-1:0] i_cfg_wdata, // Config write data
  input wire logic [CFG_W-1:0] o_cfg_rdata, // Config readback
  input wire logic o_cfg_busy, // Sweep running
  input wire logic i_base_wr, // Base write strobe
  input wire logic [ADDR_W-1:0] i_base_wdata, // Base write data
  input wire logic [ADDR_W-1:0] o_base_rdata, // Base readback
  input wire logic i_core_req, // Core request
  input wire logic i_core_we, // Core write
  input wire logic [ADDR_W-1:0] i_core_addr, // Core address
  input wire logic o_core_ack, // Core ack
  input wire logic i_dma_req, // DMA request
  input wire logic [ADDR_W-1:0] i_dma_addr, // DMA address
  input wire logic o_dma_ack, // DMA ack
  input wire logic o_dma_err, // DMA error
  input wire logic o_sys_req, // System bus request
  input wire logic [ADDR_W-1:0] o_sys_addr, // System bus address
  input wire logic i_sys_ack // System bus ack
);
  logic core_win;
  logic dma_win;
  // Window hits from the readback copy of the base
  assign core_win = o_base_rdata[0] && (i_core_addr[31:16] == o_base_rdata[31:16]);
  assign dma_win = o_base_rdata[0] && (i_dma_addr[31:16] == o_base_rdata[31:16]);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  property p_cfg_user;
    i_cfg_wr && !i_cfg_super |=> $stable(o_cfg_rdata);
  endproperty
  a_cfg_user: assert property (p_cfg_user) else $error("user write changed config");
  property p_cfg_write;
    i_cfg_wr && i_cfg_super |=> o_cfg_rdata == {1'b0, $past(i_cfg_wdata[2:0])} && o_cfg_busy;
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");
  property p_base_write;
    i_base_wr |=> o_base_rdata == {$past(i_base_wdata[31:16]), 15'h0000, $past(i_base_wdata[0])};
  endproperty
  a_base_write: assert property (p_base_write) else $error("base readback wrong");
  property p_core_sram;
    $rose(i_core_req) && !o_cfg_busy && core_win |=> o_core_ack;
  endproperty
  a_core_sram: assert property (p_core_sram) else $error("SRAM core access slow");
  property p_dma_in;
    i_dma_req && !o_dma_ack && dma_win && !i_core_req |=> o_dma_ack && !o_dma_err;
  endproperty
  a_dma_in: assert property (p_dma_in) else $error("DMA window access wrong");
  property p_dma_out;
    i_dma_req && !o_dma_ack && !dma_win |=> o_dma_ack && o_dma_err;
  endproperty
  a_dma_out: assert property (p_dma_out) else $error("DMA outside not refused");
  property p_err_ack;
    o_dma_err |-> o_dma_ack;
  endproperty
  a_err_ack: assert property (p_err_ack) else $error("DMA error without ack");
  property p_wr_sys;
    $rose(i_core_req) && i_core_we && !o_cfg_busy && !core_win |-> ##[1:3] o_sys_req;
  endproperty
  a_wr_sys: assert property (p_wr_sys) else $error("outside write not on bus");
  property p_sys_hold;
    o_sys_req && !i_sys_ack |=> o_sys_req && $stable(o_sys_addr);
  endproperty
  a_sys_hold: assert property (p_sys_hold) else $error("bus request dropped");
  property p_sys_done;
    o_sys_req && i_sys_ack |-> ##[1:2] o_core_ack;
  endproperty
  a_sys_done: assert property (p_sys_done) else $error("core not answered");
endmodule // ocm_subsystem_properties

// ### sim/sys_bus_model.sv
// Behavioural system bus responder with programmable wait
`timescale 1ns/1ps
module sys_bus_model (
  input wire logic i_clk, // System clock
  input wire logic i_rstn, // Reset, active low
  input wire logic i_req, // Bus request
  input wire logic [31:0] i_addr, // Bus address
  input wire logic [3:0] i_delay, // Wait cycles before ack
  output logic o_ack, // One-cycle ack
  output logic [31:0] o_rdata // Read data, valid with ack
);
  logic [3:0] cnt;
  // One word per request; data toggles outside ack so nothing stale passes
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ack <= 1'b0;
      o_rdata <= 32'h00000000;
      cnt <= 4'h0;
    end else begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack) begin
        if (cnt == i_delay) begin
          o_ack <= 1'b1;
          o_rdata <= {i_addr[15:0], ~i_addr[15:0]};
          cnt <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule // sys_bus_model

// ### sim/ocm_subsystem_tb.sv
// Self-checking testbench for the on-chip memory subsystem
`timescale 1ns/1ps
module ocm_subsystem_tb;
  import ocm_pkg::*;
  logic clk, rstn, cfg_wr, cfg_super, cfg_busy, base_wr, core_req, core_we, core_ifetch;
  logic core_ack, dma_req, dma_we, dma_ack, dma_err, sys_req, sys_we, sys_ack;
  logic [3:0] cfg_wdata, cfg_rdata, core_be, dma_be, sys_be, sys_dly;
  logic [31:0] base_wdata, base_rdata, core_addr, core_wdata, core_rdata, dma_addr;
  logic [31:0] dma_wdata, dma_rdata, sys_addr, sys_wdata, sys_rdata;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  ocm_subsystem u_ocm_subsystem (.i_clk(clk), .i_rstn(rstn), .i_cfg_wr(cfg_wr),
    .i_cfg_super(cfg_super), .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(cfg_rdata),
    .o_cfg_busy(cfg_busy), .i_base_wr(base_wr), .i_base_wdata(base_wdata),
    .o_base_rdata(base_rdata), .i_core_req(core_req), .i_core_we(core_we),
    .i_core_be(core_be), .i_core_ifetch(core_ifetch), .i_core_addr(core_addr),
    .i_core_wdata(core_wdata), .o_core_ack(core_ack), .o_core_rdata(core_rdata),
    .i_dma_req(dma_req), .i_dma_we(dma_we), .i_dma_be(dma_be), .i_dma_addr(dma_addr),
    .i_dma_wdata(dma_wdata), .o_dma_ack(dma_ack), .o_dma_err(dma_err),
    .o_dma_rdata(dma_rdata), .o_sys_req(sys_req), .o_sys_we(sys_we), .o_sys_be(sys_be),
    .o_sys_addr(sys_addr), .o_sys_wdata(sys_wdata), .i_sys_ack(sys_ack),
    .i_sys_rdata(sys_rdata));
  sys_bus_model u_sys_bus_model (.i_clk(clk), .i_rstn(rstn), .i_req(sys_req),
    .i_addr(sys_addr), .i_delay(sys_dly), .o_ack(sys_ack), .o_rdata(sys_rdata));
  // Clock and cycle ceiling
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 40000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Core access held until ack; lat counts cycles from take to ack
  task automatic core_acc(input logic we, input logic [31:0] a, input logic [31:0] wd,
    input logic f, output logic [31:0] rd, output int lat);
    @(negedge clk);
    {core_req, core_we, core_ifetch, core_be, core_addr, core_wdata} = {1'b1, we, f, 4'hf, a, wd};
    lat = 0;
    do begin @(negedge clk); lat++; end while (core_ack !== 1'b1 && lat < 300);
    rd = core_rdata;
    @(negedge clk) core_req = 1'b0;
  endtask
  task automatic dma_acc(input logic we, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err, output int lat);
    @(negedge clk);
    {dma_req, dma_we, dma_be, dma_addr, dma_wdata} = {1'b1, we, 4'hf, a, wd};
    lat = 0;
    do begin @(negedge clk); lat++; end while (dma_ack !== 1'b1 && lat < 300);
    rd = dma_rdata;
    err = dma_err;
    @(negedge clk) dma_req = 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (cfg_busy !== 1'b0 && n < 5000) begin @(negedge clk); n++; end
    check("sweep length", 32'(n <= 4200), 32'h1);
  endtask
  task automatic cfg_write(input logic s, input logic [3:0] d);
    @(negedge clk) {cfg_wr, cfg_super, cfg_wdata} = {1'b1, s, d};
    @(negedge clk) cfg_wr = 1'b0;
  endtask
  // Scenarios
  task automatic t_reset();
    check("cfg reset", 32'(cfg_rdata), 32'(CFG_RESET));
    check("base reset", base_rdata, 32'h00000000);
    wait_idle();
  endtask
  task automatic t_sram();
    logic [31:0] rd;
    int lat;
    @(negedge clk) {base_wr, base_wdata} = {1'b1, 32'h24687ff1};
    @(negedge clk) base_wr = 1'b0;
    check("base readback", base_rdata, 32'h24680001);
    for (int b = 0; b < 4; b++) core_acc(1'b1, 32'h24680000 + (b << 14) + 4 * b,
      32'hc0de0000 + b, 1'b0, rd, lat);
    for (int b = 0; b < 4; b++) begin
      core_acc(1'b0, 32'h24680000 + (b << 14) + 4 * b, 0, b[0], rd, lat);
      check("sram data", rd, 32'hc0de0000 + b);
      check("sram latency", lat, 1);
    end
  endtask
  task automatic t_dual();
    logic [31:0] rc, rdm;
    logic err;
    int lc, ld;
    fork
      core_acc(1'b1, 32'h24680010, 32'h0badf00d, 1'b0, rc, lc);
      dma_acc(1'b0, 32'h24688008, 0, rdm, err, ld);
    join
    check("dma data", rdm, 32'hc0de0002);
    check("both fast", 32'(lc + ld), 2);
    // Same block from both ports: core served first, DMA one cycle later
    fork
      core_acc(1'b0, 32'h24684004, 0, 1'b0, rc, lc);
      dma_acc(1'b0, 32'h24684004, 0, rdm, err, ld);
    join
    check("clash core first", 32'(lc), 1);
    check("clash dma waits", 32'(ld), 2);
    check("clash dma data", rdm, 32'hc0de0001);
    dma_acc(1'b1, 32'h2468c020, 32'h12345678, rdm, err, ld);
    core_acc(1'b0, 32'h2468c020, 0, 1'b0, rc, lc);
    check("dma write seen", rc, 32'h12345678);
    dma_acc(1'b0, 32'h10000000, 0, rdm, err, ld);
    check("dma outside err", 32'(err), 1);
  endtask
  // Every organisation: first access misses, second hits only if that side is cached
  task automatic t_modes();
    logic [31:0] rd, a;
    int lat;
    cfg_write(1'b0, 4'h5);
    check("user write ignored", 32'(cfg_rdata), 32'h0);
    for (int m = 0; m < 3; m++) begin
      sys_dly = 4'(2 * m + 1);
      cfg_write(1'b1, {1'b1, m[1:0], 1'b1});
      check("cfg mode", 32'(cfg_rdata), 32'({m[1:0], 1'b1}));
      wait_idle();
      for (int f = 0; f < 2; f++) begin
        a = 32'h10000000 + 32'h100 * f + 16 * m;
        core_acc(1'b0, a, 0, f[0], rd, lat);
        check("miss data", rd, {a[15:0], ~a[15:0]});
        check("miss slow", 32'(lat > 1), 1);
        core_acc(1'b0, a, 0, f[0], rd, lat);
        check("second data", rd, {a[15:0], ~a[15:0]});
        check("hit one cycle", 32'(lat == 1), 32'(f ? m != 1 : m != 0));
      end
    end
    // Data-side line filled in split mode; a write-through must drop it
    a = 32'h10000020;
    core_acc(1'b1, a, 32'h55aa55aa, 1'b0, rd, lat);
    check("sys write data", sys_wdata, 32'h55aa55aa);
    check("sys write flags", 32'({sys_we, sys_be}), 32'h1f);
    check("sys write addr", sys_addr, a);
    core_acc(1'b0, a, 0, 1'b0, rd, lat);
    check("write invalidates", 32'(lat > 1), 1);
  endtask
  initial begin
    {rstn, cfg_wr, cfg_super, cfg_wdata, base_wr, base_wdata} = '0;
    {core_req, core_we, core_be, core_ifetch, core_addr, core_wdata} = '0;
    {dma_req, dma_we, dma_be, dma_addr, dma_wdata} = '0;
    sys_dly = 4'h2;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_sram();
    t_dual();
    t_modes();
    end_of_test();
  end
endmodule // ocm_subsystem_tb
bind ocm_subsystem ocm_subsystem_properties u_ocm_subsystem_properties (.i_clk(i_clk),
  .i_rstn(i_rstn), .i_cfg_wr(i_cfg_wr), .i_cfg_super(i_cfg_super),
  .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .o_cfg_busy(o_cfg_busy),
  .i_base_wr(i_base_wr), .i_base_wdata(i_base_wdata), .o_base_rdata(o_base_rdata),
  .i_core_req(i_core_req), .i_core_we(i_core_we), .i_core_addr(i_core_addr),
  .o_core_ack(o_core_ack), .i_dma_req(i_dma_req), .i_dma_addr(i_dma_addr),
  .o_dma_ack(o_dma_ack), .o_dma_err(o_dma_err), .o_sys_req(o_sys_req),
  .o_sys_addr(o_sys_addr), .i_sys_ack(i_sys_ack));
